// [rtl/prsw_pkg.sv]
// package: register map, field positions, timing for the phy reset/wake block
package prsw_pkg;
    localparam logic [11:0] PMCTL_OFFS      = 12'h000;
    localparam logic [11:0] AUXCTL_OFFS     = 12'h004;
    localparam logic [11:0] AUXSTAT_OFFS    = 12'h008;
    // pm control bit positions
    localparam int READY_BIT     = 7;
    localparam int SLEEP_LSB     = 5;
    localparam int XRST_BIT      = 4;
    localparam int LAN_WAKE_BIT  = 3;
    localparam int IRQ_WAKE_BIT  = 2;
    // aux control bit positions
    localparam int RES_CLR_BIT   = 0;
    localparam int SKIP_REF_BIT  = 1;
    // reset values
    localparam logic [1:0] SLEEP_RST  = 2'h2;
    localparam logic       RES_CLR_RST = 1'b1;
    localparam logic       SKIP_REF_RST = 1'b0;
    // timing
    localparam int CLK_HZ        = 10_000_000;
    localparam int HOLD_SHORT_US = 4_000;
    localparam int HOLD_LONG_US  = 128_000;
    localparam int HOLD_SHORT_CYC = (CLK_HZ / 1_000_000) * HOLD_SHORT_US;
    localparam int HOLD_LONG_CYC  = (CLK_HZ / 1_000_000) * HOLD_LONG_US;

    typedef enum logic [1:0] {
        SLEEP_A = 2'h0,
        SLEEP_B = 2'h1,
        SLEEP_C = 2'h2,
        SLEEP_D = 2'h3
    } prsw_sleep_t;

    typedef struct packed {
        logic       lan_wake_enable;
        logic       transceiver_irq_wake_enable;
        logic [1:0] sleep_mode;
    } prsw_wake_cfg_t;
endpackage : prsw_pkg

// [rtl/prsw_ctl.sv]
// phy reset sequencer, ready indicator and wake enables behind an apb slave
//
// Decided for this implementation: register access over APB and the register offsets.
`timescale 1ns/10ps

// Notes on behaviour
// RULE1: ready bit read-only, zero after reset
// RULE2: ready low until phy operational
// RULE3: ready low while eeprom/otp loading
// RULE4: two-bit sleep selector at bits 6:5
// RULE5: unconfigured normal entry restores selector 10b
// RULE6: software keeps variant c when unconfigured
// RULE7: variants a and b behave identically
// RULE8: writing one resets phy, 4 ms min
// RULE9: request bit self-clears on phy release
// RULE10: writes ignored while request bit high; here only the request bit ignores them, sleep and wake fields still update
// RULE11: request clears ready; ready returns operational
// RULE12: skip-wait setting extends hold to 128 ms
// RULE13: software resets phy after variant c resume
// RULE14: bit 3 enables lan wake events
// RULE15: bit 2 enables phy irq wake
// RULE16: resume clears enables when setting active
// RULE17: only remote-wakeup resumes clear; default one
// RULE18: phy held reset in variant c
// RULE19: hold timed by system clock counter
module prsw_ctl #(
    parameter int HOLD_SHORT = prsw_pkg::HOLD_SHORT_CYC,
    parameter int HOLD_LONG  = prsw_pkg::HOLD_LONG_CYC
) (
    // clock and reset
    input  wire logic                     ref_clk_in,
    input  wire logic                     rst_n_in,
    // apb slave
    input  wire logic                     psel_in,
    input  wire logic                     penable_in,
    input  wire logic                     pwrite_in,
    input  wire logic [11:0]              paddr_in,
    input  wire logic [31:0]              pwdata_in,
    output logic      [31:0]              prdata_out,
    output logic                          pready_out,
    output logic                          pslverr_out,
    // device state
    input  wire logic                     cfg_loading_in,
    input  wire logic                     unconfig_entry_in,
    input  wire logic                     in_sleep_c_in,
    input  wire logic                     resume_done_in,
    input  wire logic                     resume_remote_in,
    // wake sources
    input  wire logic                     lan_wake_det_in,
    input  wire logic                     phy_irq_in,
    output logic                          wake_event_out,
    output prsw_pkg::prsw_wake_cfg_t      wake_cfg_out,
    output logic                          sleep_a_or_b_out,
    // phy
    input  wire logic                     phy_operational_in,
    output logic                          phy_reset_n_out
);
    localparam int CW = $clog2(HOLD_LONG + 1);

    // the minimum-length assertion unrolls eight cycles
    if (HOLD_SHORT < 8 || HOLD_LONG < HOLD_SHORT) begin : g_bad_hold
        $error("prsw_ctl: hold counts invalid");
    end

    logic [1:0]    sleep_q;
    logic          xrst_req_q;
    logic          lan_wake_q;
    logic          irq_wake_q;
    logic          res_clr_q;
    logic          skip_ref_q;
    logic          ready_q;
    logic [CW-1:0] hold_cnt_q;
    logic          hold_done;
    logic          wr_acc;
    logic          rd_acc;
    logic          hit_pm;
    logic          hit_aux;
    logic          hit_stat;
    logic          phy_in_reset;
    logic          clr_wake;
    logic          rd_wait_q;

    // reads take one wait state so prdata is a flop yet valid at the
    // edge where pready is sampled; writes complete at once
    assign pready_out  = pwrite_in || rd_wait_q;
    assign hit_pm      = paddr_in == prsw_pkg::PMCTL_OFFS;
    assign hit_aux     = paddr_in == prsw_pkg::AUXCTL_OFFS;
    assign hit_stat    = paddr_in == prsw_pkg::AUXSTAT_OFFS;
    assign pslverr_out = psel_in && penable_in && pready_out
                         && !(hit_pm || hit_aux || hit_stat);
    assign wr_acc = psel_in && penable_in && pwrite_in;
    assign rd_acc = psel_in && penable_in && !pwrite_in && !rd_wait_q;

    always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            rd_wait_q <= 1'b0;
        end else begin
            rd_wait_q <= rd_acc;
        end
    end

    // hold length chosen when the request is taken
    assign hold_done = hold_cnt_q == '0;
    assign phy_in_reset = xrst_req_q || in_sleep_c_in;     // [RULE18]
    assign clr_wake = resume_done_in && resume_remote_in
                      && res_clr_q;                         // [RULE16] [RULE17]

    always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            sleep_q <= prsw_pkg::SLEEP_RST;
        end else if (unconfig_entry_in) begin
            sleep_q <= prsw_pkg::SLEEP_RST;                 // [RULE5]
        end else if (wr_acc && hit_pm) begin
            sleep_q <= pwdata_in[prsw_pkg::SLEEP_LSB +: 2]; // [RULE4]
        end
    end

    always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            xrst_req_q <= 1'b0;
            hold_cnt_q <= '0;
        end else if (xrst_req_q) begin
            // writes to the bit are ignored until the hold ends [RULE10]
            if (hold_done) begin
                xrst_req_q <= 1'b0;                         // [RULE9]
            end else begin
                hold_cnt_q <= hold_cnt_q - 1'b1;            // [RULE19]
            end
        end else if (wr_acc && hit_pm && pwdata_in[prsw_pkg::XRST_BIT]) begin
            xrst_req_q <= 1'b1;                             // [RULE8]
            hold_cnt_q <= skip_ref_q ? CW'(HOLD_LONG - 1)
                                     : CW'(HOLD_SHORT - 1); // [RULE12]
        end
    end

    always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            lan_wake_q <= 1'b0;
            irq_wake_q <= 1'b0;
        end else if (clr_wake) begin
            lan_wake_q <= 1'b0;                             // [RULE16]
            irq_wake_q <= 1'b0;
        end else if (wr_acc && hit_pm) begin
            lan_wake_q <= pwdata_in[prsw_pkg::LAN_WAKE_BIT];
            irq_wake_q <= pwdata_in[prsw_pkg::IRQ_WAKE_BIT];
        end
    end

    always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            res_clr_q  <= prsw_pkg::RES_CLR_RST;            // [RULE17]
            skip_ref_q <= prsw_pkg::SKIP_REF_RST;
        end else if (wr_acc && hit_aux) begin
            res_clr_q  <= pwdata_in[prsw_pkg::RES_CLR_BIT];
            skip_ref_q <= pwdata_in[prsw_pkg::SKIP_REF_BIT];
        end
    end

    // ready drops the cycle a reset request is taken
    always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            ready_q <= 1'b0;                                // [RULE1]
        end else if (wr_acc && hit_pm && !xrst_req_q
                     && pwdata_in[prsw_pkg::XRST_BIT]) begin
            ready_q <= 1'b0;                                // [RULE11]
        end else begin
            ready_q <= !phy_in_reset && phy_operational_in
                       && !cfg_loading_in;                  // [RULE2] [RULE3]
        end
    end

    always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            prdata_out <= '0;
        end else if (rd_acc) begin
            prdata_out <= '0;
            if (hit_pm) begin
                prdata_out[prsw_pkg::READY_BIT]           <= ready_q;
                prdata_out[prsw_pkg::SLEEP_LSB +: 2]      <= sleep_q;
                prdata_out[prsw_pkg::XRST_BIT]            <= xrst_req_q;
                prdata_out[prsw_pkg::LAN_WAKE_BIT]        <= lan_wake_q;
                prdata_out[prsw_pkg::IRQ_WAKE_BIT]        <= irq_wake_q;
            end else if (hit_aux) begin
                prdata_out[prsw_pkg::RES_CLR_BIT]         <= res_clr_q;
                prdata_out[prsw_pkg::SKIP_REF_BIT]        <= skip_ref_q;
            end else if (hit_stat) begin
                prdata_out[0] <= phy_in_reset;
                prdata_out[1] <= phy_operational_in;
            end
        end
    end

    // phy pin follows the request and the variant c hold
    assign phy_reset_n_out = !phy_in_reset;
    assign wake_event_out  = (lan_wake_q && lan_wake_det_in)  // [RULE14]
                           || (irq_wake_q && phy_irq_in);     // [RULE15]
    assign wake_cfg_out.lan_wake_enable             = lan_wake_q;
    assign wake_cfg_out.transceiver_irq_wake_enable = irq_wake_q;
    assign wake_cfg_out.sleep_mode                  = sleep_q;
    // a and b codes map to one behaviour downstream
    assign sleep_a_or_b_out = sleep_q[1] == 1'b0;             // [RULE7]

    // helper state for the hold length checks only
    logic [CW-1:0] held_q;
    logic          long_q;

    always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            held_q <= '0;
            long_q <= 1'b0;
        end else if (xrst_req_q) begin
            held_q <= held_q + 1'b1;
        end else begin
            held_q <= '0;
            long_q <= skip_ref_q;
        end
    end

    a_hold_min_len: assert property (@(posedge ref_clk_in) // [RULE8]
        disable iff (!rst_n_in)
        $rose(xrst_req_q) |-> xrst_req_q [*8])
        else $error("phy reset request released too early");
    a_hold_short_len: assert property (@(posedge ref_clk_in) // [RULE8]
        disable iff (!rst_n_in)
        $fell(xrst_req_q) |-> held_q >= HOLD_SHORT)
        else $error("phy reset shorter than minimum hold");
    a_hold_long_len: assert property (@(posedge ref_clk_in) // [RULE12]
        disable iff (!rst_n_in)
        $fell(xrst_req_q) && long_q |-> held_q >= HOLD_LONG)
        else $error("long phy reset hold cut short");
    a_hold_counter: assert property (@(posedge ref_clk_in) // [RULE19]
        disable iff (!rst_n_in)
        xrst_req_q && !hold_done
        |=> hold_cnt_q == $past(hold_cnt_q) - 1'b1)
        else $error("hold counter did not step");
    a_phy_pin_req: assert property (@(posedge ref_clk_in) // [RULE8]
        disable iff (!rst_n_in)
        xrst_req_q |-> !phy_reset_n_out)
        else $error("phy pin released during request");
    a_ready_low_rst: assert property (@(posedge ref_clk_in) // [RULE2]
        disable iff (!rst_n_in)
        xrst_req_q |=> !ready_q)
        else $error("ready high during phy reset");
    a_ready_needs_phy: assert property (@(posedge ref_clk_in) // [RULE2]
        disable iff (!rst_n_in)
        ready_q |-> $past(phy_operational_in))
        else $error("ready high without operational phy");
    a_ready_cfg_load: assert property (@(posedge ref_clk_in) // [RULE3]
        disable iff (!rst_n_in)
        cfg_loading_in |=> !ready_q)
        else $error("ready high during config load");
    a_ready_clr_req: assert property (@(posedge ref_clk_in) // [RULE11]
        disable iff (!rst_n_in)
        $rose(xrst_req_q) |-> !ready_q)
        else $error("ready not cleared by reset request");
    a_ready_returns: assert property (@(posedge ref_clk_in) // [RULE11]
        disable iff (!rst_n_in)
        !phy_in_reset && phy_operational_in && !cfg_loading_in && !wr_acc
        |=> ready_q)
        else $error("ready did not return");
    a_sleep_c_ready: assert property (@(posedge ref_clk_in) // [RULE18]
        disable iff (!rst_n_in)
        in_sleep_c_in |=> !ready_q)
        else $error("ready high in variant c");
    a_sleep_write: assert property (@(posedge ref_clk_in) // [RULE4]
        disable iff (!rst_n_in)
        wr_acc && hit_pm && !unconfig_entry_in
        |=> sleep_q == $past(pwdata_in[prsw_pkg::SLEEP_LSB +: 2]))
        else $error("sleep selector write lost");
    a_sleep_unconf: assert property (@(posedge ref_clk_in) // [RULE5]
        disable iff (!rst_n_in)
        unconfig_entry_in |=> sleep_q == prsw_pkg::SLEEP_RST)
        else $error("sleep selector not restored");
    a_sleep_ab: assert property (@(posedge ref_clk_in) // [RULE7]
        disable iff (!rst_n_in)
        sleep_a_or_b_out == (sleep_q == prsw_pkg::SLEEP_A
                             || sleep_q == prsw_pkg::SLEEP_B))
        else $error("variant a or b flag wrong");
    a_wake_write: assert property (@(posedge ref_clk_in) // [RULE14] [RULE15]
        disable iff (!rst_n_in)
        wr_acc && hit_pm && !clr_wake
        |=> lan_wake_q == $past(pwdata_in[prsw_pkg::LAN_WAKE_BIT])
            && irq_wake_q == $past(pwdata_in[prsw_pkg::IRQ_WAKE_BIT]))
        else $error("wake enable write lost");
    a_wake_clear: assert property (@(posedge ref_clk_in) // [RULE16]
        disable iff (!rst_n_in)
        clr_wake |=> !lan_wake_q && !irq_wake_q)
        else $error("wake enables not cleared");
    a_host_resume: assert property (@(posedge ref_clk_in) // [RULE17]
        disable iff (!rst_n_in)
        resume_done_in && !resume_remote_in && !wr_acc
        |=> $stable(lan_wake_q) && $stable(irq_wake_q))
        else $error("host resume altered wake enables");
    a_aux_resclr: assert property (@(posedge ref_clk_in) // [RULE17]
        disable iff (!rst_n_in)
        wr_acc && hit_aux
        |=> res_clr_q == $past(pwdata_in[prsw_pkg::RES_CLR_BIT]))
        else $error("resume clear setting write lost");
    a_aux_skip: assert property (@(posedge ref_clk_in) // [RULE12]
        disable iff (!rst_n_in)
        wr_acc && hit_aux
        |=> skip_ref_q == $past(pwdata_in[prsw_pkg::SKIP_REF_BIT]))
        else $error("skip wait setting write lost");
    a_req_self_clr: assert property (@(posedge ref_clk_in) // [RULE9]
        disable iff (!rst_n_in)
        xrst_req_q && hold_done |=> !xrst_req_q)
        else $error("request bit did not self clear");
    a_req_ignore_wr: assert property (@(posedge ref_clk_in) // [RULE10]
        disable iff (!rst_n_in)
        xrst_req_q && !hold_done |=> xrst_req_q)
        else $error("reset in progress was cancelled");
    a_phy_pin: assert property (@(posedge ref_clk_in) // [RULE18]
        disable iff (!rst_n_in)
        in_sleep_c_in |-> !phy_reset_n_out)
        else $error("phy not held in reset in variant c");
    a_wake_gate: assert property (@(posedge ref_clk_in) // [RULE14]
        disable iff (!rst_n_in)
        !lan_wake_q && !irq_wake_q |-> !wake_event_out)
        else $error("wake event without enable");
    a_lan_wake_pass: assert property (@(posedge ref_clk_in) // [RULE14]
        disable iff (!rst_n_in)
        lan_wake_q && lan_wake_det_in |-> wake_event_out)
        else $error("enabled lan wake not passed");
    a_irq_wake_pass: assert property (@(posedge ref_clk_in) // [RULE15]
        disable iff (!rst_n_in)
        irq_wake_q && phy_irq_in |-> wake_event_out)
        else $error("enabled phy irq wake not passed");
    a_irq_wake_gate: assert property (@(posedge ref_clk_in) // [RULE15]
        disable iff (!rst_n_in)
        !irq_wake_q && !(lan_wake_q && lan_wake_det_in)
        |-> !wake_event_out)
        else $error("phy irq woke without enable");
    a_rd_wait_state: assert property (@(posedge ref_clk_in)
        disable iff (!rst_n_in)
        psel_in && penable_in && !pwrite_in && !rd_wait_q |-> !pready_out)
        else $error("read answered before data was loaded");
    a_wr_no_wait: assert property (@(posedge ref_clk_in)
        disable iff (!rst_n_in)
        psel_in && penable_in && pwrite_in |-> pready_out)
        else $error("write stalled");
    a_prdata_hold: assert property (@(posedge ref_clk_in)
        disable iff (!rst_n_in)
        !rd_acc |=> $stable(prdata_out))
        else $error("read data changed without a read");

    c_phy_reset: cover property (@(posedge ref_clk_in)
        disable iff (!rst_n_in) $fell(xrst_req_q));
    c_ready_up: cover property (@(posedge ref_clk_in)
        disable iff (!rst_n_in) $rose(ready_q));
    c_remote_clr: cover property (@(posedge ref_clk_in)
        disable iff (!rst_n_in) clr_wake);
    c_long_hold: cover property (@(posedge ref_clk_in)
        disable iff (!rst_n_in) $fell(xrst_req_q) && long_q);
    c_rd_wait: cover property (@(posedge ref_clk_in)
        disable iff (!rst_n_in) rd_wait_q);
endmodule : prsw_ctl

// [sim/prsw_phy_model.sv]
// behavioural phy: operational a few cycles after reset release
`timescale 1ns/10ps
module prsw_phy_model #(
    parameter int WAKE_CYC = 5
) (
    input  wire logic ref_clk_in,
    input  wire logic rst_n_in,
    input  wire logic phy_reset_n_in,
    output logic      phy_operational_out
);
    int cnt_q;
    // operational drops the cycle after reset is asserted; the count restarts from zero, even mid-count
    always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            cnt_q <= 0;
        end else if (!phy_reset_n_in) begin
            cnt_q <= 0;
        end else if (cnt_q < WAKE_CYC) begin
            cnt_q <= cnt_q + 1;
        end
    end
    assign phy_operational_out = (cnt_q == WAKE_CYC);
endmodule : prsw_phy_model

// [sim/prsw_ctl_tb.sv]
// self-checking bench for the phy reset, ready and wake block
`timescale 1ns/10ps
module prsw_ctl_tb;
    localparam int HS = 20;
    localparam int HL = 40;
    logic        clk, rst_n, psel, pen, pwr, cfg_ld, unc, slp_c;
    logic        res_done, res_rem, lan, irq, phy_op, err;
    logic        pready, pslverr, wake_ev, a_or_b, transceiver_reset_request_n;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [15:0] seed;
    prsw_pkg::prsw_wake_cfg_t wcfg;
    int          errors, n_checks, cyc, low_cnt;

    prsw_ctl #(.HOLD_SHORT(HS), .HOLD_LONG(HL)) dut (
        .ref_clk_in(clk), .rst_n_in(rst_n), .psel_in(psel),
        .penable_in(pen), .pwrite_in(pwr), .paddr_in(paddr),
        .pwdata_in(pwdata), .prdata_out(prdata), .pready_out(pready),
        .pslverr_out(pslverr), .cfg_loading_in(cfg_ld),
        .unconfig_entry_in(unc), .in_sleep_c_in(slp_c),
        .resume_done_in(res_done), .resume_remote_in(res_rem),
        .lan_wake_det_in(lan), .phy_irq_in(irq),
        .wake_event_out(wake_ev), .wake_cfg_out(wcfg),
        .sleep_a_or_b_out(a_or_b), .phy_operational_in(phy_op),
        .phy_reset_n_out(transceiver_reset_request_n));
    prsw_phy_model phy (.ref_clk_in(clk), .rst_n_in(rst_n),
        .phy_reset_n_in(transceiver_reset_request_n), .phy_operational_out(phy_op));

    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction : lfsr
    task automatic chk(input string nm, input logic [31:0] e, g);
        n_checks++;
        if (g !== e) begin
            errors++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] d);
        @(posedge clk);
        psel   <= 1'b1;
        pwr    <= w;
        paddr  <= a;
        pwdata <= d;
        @(posedge clk);
        pen <= 1'b1;
        // only the bench timeout ends a stuck wait
        do begin
            @(posedge clk);
        end while (pready !== 1'b1);
        err = pslverr;
        rd  = prdata;
        psel <= 1'b0;
        pen  <= 1'b0;
    endtask : apb
    task automatic rdpm(input string nm, input logic [7:0] e);
        apb(1'b0, prsw_pkg::PMCTL_OFFS, 32'h0);
        chk(nm, {24'h0, e}, {24'h0, rd[7:0]});
    endtask : rdpm
    task automatic hold_test(input int h);
        int t;
        // let a pin release from the step before settle first
        @(posedge clk);
        low_cnt = 0;
        apb(1'b1, prsw_pkg::PMCTL_OFFS, 32'h50);
        rdpm("req set", 8'h50);
        apb(1'b1, prsw_pkg::PMCTL_OFFS, 32'h40);
        rdpm("req kept", 8'h50);
        for (t = 0; t < 200 && transceiver_reset_request_n !== 1'b1; t++) @(posedge clk);
        chk("hold", h, low_cnt);
        rdpm("req cleared", 8'h40);
        repeat (10) @(posedge clk);
        rdpm("ready back", 8'hc0);
        $display("hold test %0d done", h);
    endtask : hold_test
    task automatic resume(input logic rem, input logic [7:0] e);
        apb(1'b1, prsw_pkg::PMCTL_OFFS, 32'h4c);
        res_done <= 1'b1;
        res_rem  <= rem;
        @(posedge clk);
        res_done <= 1'b0;
        rdpm("resume", e);
    endtask : resume
    task automatic summarize();
        $display("checks %0d mismatches %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : summarize

    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    // a stuck handshake ends here; a stuck phy reset ends the hold wait after 200 cycles
    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            errors++;
            summarize();
        end
    end
    always @(posedge clk) begin
        if (transceiver_reset_request_n === 1'b0) low_cnt++;
    end

    initial begin
        logic [31:0] v;
        {rst_n, psel, pen, pwr, cfg_ld, unc, slp_c} = '0;
        {res_done, res_rem, lan, irq, paddr, pwdata} = '0;
        seed = 16'h3;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        rdpm("pm reset", 8'h40);
        apb(1'b0, prsw_pkg::AUXCTL_OFFS, 32'h0);
        chk("aux reset", 32'h1, {30'h0, rd[1:0]});
        repeat (10) @(posedge clk);
        rdpm("ready", 8'hc0);
        cfg_ld <= 1'b1;
        rdpm("loading", 8'h40);
        cfg_ld <= 1'b0;
        for (int i = 0; i < 8; i++) begin
            seed = lfsr(seed);
            v = {25'h0, i[1:0], 1'b0, seed[1:0], 2'h0};
            apb(1'b1, prsw_pkg::PMCTL_OFFS, v);
            rdpm("pm rw", v[7:0] | 8'h80);
            chk("a or b", {31'h0, i[1:0] < 2}, {31'h0, a_or_b});
            lan <= seed[2];
            irq <= seed[3];
            @(posedge clk);
            @(negedge clk);
            chk("wake", {31'h0, (seed[2] & v[3]) | (seed[3] & v[2])},
                {31'h0, wake_ev});
        end
        unc <= 1'b1;
        @(posedge clk);
        unc <= 1'b0;
        rdpm("unconfig", 8'hc0 | (v[7:0] & 8'h0c));
        $display("register test done");
        resume(1'b1, 8'hc0);
        resume(1'b0, 8'hcc);
        apb(1'b1, prsw_pkg::AUXCTL_OFFS, 32'h0);
        resume(1'b1, 8'hcc);
        apb(1'b1, 12'h00c, 32'hff);
        chk("slverr", 32'h1, {31'h0, err});
        $display("resume test done");
        slp_c <= 1'b1;
        @(posedge clk);
        @(negedge clk);
        chk("sleep c rst", 32'h0, {31'h0, transceiver_reset_request_n});
        rdpm("sleep c", 8'h4c);
        slp_c <= 1'b0;
        hold_test(HS);
        apb(1'b1, prsw_pkg::AUXCTL_OFFS, 32'h2);
        hold_test(HL);
        summarize();
    end
endmodule : prsw_ctl_tb
